/* File: hdl/serial_debug_pkg.sv */
/*
 serial_debug_pkg: constants shared by the single-wire serial debug unit.
 assumes: sys_clk at 40 MHz; baud limits scale with the system clock.
*/
package serial_debug_pkg;
   localparam int SYS_CLK_HZ = 40_000_000;
   // baud limits printed for a reference clock; the ratio holds at any clock
   localparam int REF_CLK_HZ = 20_000_000;
   localparam int REF_MAX_BAUD = 2_500_000;
   localparam int REF_MIN_BAUD = 39_100;
   localparam int MIN_BIT_CLKS = REF_CLK_HZ / REF_MAX_BAUD;
   localparam int MAX_BIT_CLKS = (REF_CLK_HZ + REF_MIN_BAUD - 1) / REF_MIN_BAUD;
   localparam int BIT_W = 10;
   localparam int MEAS_W = 13;
   localparam int CAL_LOW_BITS = 8;
   localparam int BREAK_BITS = 10;
   localparam logic [7:0] CAL_CHAR = 8'h80;
   localparam int TX_FIFO_DEPTH = 16;

   // true for the bytes that may run outside debug mode
   function automatic logic cmd_free(input logic [7:0] c);
      return (c == 8'h00) || (c == 8'h02) || (c == 8'h04) || (c == 8'h05);
   endfunction

   // true for the bytes that the read-protect option blocks outright
   function automatic logic cmd_protected(input logic [7:0] c);
      return (c == 8'h06) || (c == 8'h07) || ((c >= 8'h0a) && (c <= 8'h0d))
         || ((c >= 8'h10) && (c <= 8'h12));
   endfunction

   // true for listed command bytes; everything else is reserved
   function automatic logic cmd_known(input logic [7:0] c);
      return ((c <= 8'h12) && (c != 8'h0f)) || (c == 8'h18) || (c == 8'h19)
         || (c == 8'h1b);
   endfunction
endpackage

/* File: hdl/byte_fifo.sv */
/*
 byte_fifo: synchronous fifo with valid/ready on both sides.
 assumes: one clock; in_ready and out_valid come from flip-flops.
*/
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready <= (next_count != DEPTH_C);
         out_valid <= (next_count != '0);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // byte_fifo

/* File: hdl/autobaud_detector.sv */
/*
 autobaud_detector: times the calibration character and watches for a break.
 assumes: line_level is already synchronised to sys_clk.
*/
`timescale 1ns/10ps
module autobaud_detector
   import serial_debug_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic line_level,
   output logic locked,
   output logic [BIT_W-1:0] bit_clks
);
   typedef enum logic [2:0] {AB_RESET, AB_MEASURE, AB_WAIT_HIGH, AB_LOCKED} ab_state_e;

   localparam logic [MEAS_W-1:0] MEAS_MAX = MEAS_W'(CAL_LOW_BITS * MAX_BIT_CLKS);
   localparam logic [MEAS_W-1:0] MEAS_MIN = MEAS_W'(CAL_LOW_BITS * MIN_BIT_CLKS);

   ab_state_e state, next_state;
   logic [MEAS_W-1:0] meas, next_meas;
   logic [BIT_W-1:0] next_bit_clks;
   logic next_locked, line_prev;
   logic [MEAS_W+3:0] break_lim;

   // ten bit times of low line
   assign break_lim = (MEAS_W+4)'(BREAK_BITS) * {{(MEAS_W+4-BIT_W){1'b0}}, bit_clks};

   always_comb begin
      next_state = state;
      next_meas = meas;
      next_bit_clks = bit_clks;
      next_locked = locked;
      case (state)
         AB_RESET: begin
            next_locked = 1'b0;
            next_meas = '0;
            if (line_prev && !line_level) begin
               next_state = AB_MEASURE;
            end
         end
         AB_MEASURE: begin
            // 80h sent lsb first: start bit plus seven zeros are low
            if (!line_level) begin
               if (meas == MEAS_MAX) begin
                  next_state = AB_WAIT_HIGH; // RL4
               end else begin
                  next_meas = meas + 1'b1; // RL14
               end
            end else if (meas + 1'b1 < MEAS_MIN) begin
               next_state = AB_RESET;
            end else begin
               next_bit_clks = BIT_W'((meas + 1'b1 + 4'h4) >> 3); // RL14 RL3
               next_locked = 1'b1; // RL6
               next_meas = '0;
               next_state = AB_LOCKED;
            end
         end
         AB_WAIT_HIGH: begin
            next_locked = 1'b0;
            if (line_level) begin
               next_state = AB_RESET;
            end
         end
         AB_LOCKED: begin
            if (line_level) begin
               next_meas = '0;
            end else if ({4'h0, meas} + 1'b1 >= break_lim) begin
               next_locked = 1'b0; // RL2
               next_state = AB_WAIT_HIGH;
            end else begin
               next_meas = meas + 1'b1;
            end
         end
         default: next_state = AB_RESET;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= AB_RESET;
         meas <= '0;
         bit_clks <= BIT_W'(MAX_BIT_CLKS);
         locked <= 1'b0;
         line_prev <= 1'b1;
      end else begin
         state <= next_state;
         meas <= next_meas;
         bit_clks <= next_bit_clks;
         locked <= next_locked;
         line_prev <= line_level;
      end
   end
endmodule // autobaud_detector

/* File: hdl/serial_debug_unit.sv */
/*
 serial_debug_unit: single-wire open-drain debug line with autobaud,
 byte receive, fifo-buffered transmit, drive assist and command gating.
 assumes: external pull-up on the line; debug core supplies the command
 framing (cmd_expect) and the register target kind for register commands.
*/
// Overview of operation
// RL1: link works between 8 and 512 system clocks per bit.
// RL2: line low ten bit times resets the autobaud detector.
// RL3: host sends 80h after reset so the rate is measured.
// RL4: measurement overflow leaves the detector reset.
// RL5: high-speed synchronous use needs an external system clock source.
// RL6: no mode select; the measured rate simply becomes the baud rate.
// RL7: full drive drives high and low from start bit to stop middle.
// RL8: assist alone drives high bits until line reads high or bit centre.
// RL9: both bits set drive high one clock at each rising data edge.
// RL10: outside debug mode or under read protect some commands refuse.
// RL11: command is one byte; unlisted values are reserved.
// RL12: under read protect register commands reach peripherals but not ram.
// RL13: otherwise the line is only pulled low or released.
// RL14: bit period comes from counting clocks across the 80h low run.
`timescale 1ns/10ps
module serial_debug_unit
   import serial_debug_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   input wire logic full_drive,
   input wire logic drive_high_assist_bit,
   input wire logic debug_mode,
   input wire logic read_protect,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic cmd_expect,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic cmd_accept,
   output logic cmd_refused,
   output logic cmd_reserved,
   input wire logic reg_target_ram,
   output logic reg_access_ok,
   output logic baud_locked,
   output logic [BIT_W-1:0] baud_bit_clks
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // line synchroniser and autobaud

   logic line_meta, line_sync, line_prev;
   logic locked;
   logic [BIT_W-1:0] bit_clks, half_clks, last_clk;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
         line_prev <= 1'b1;
      end else begin
         line_meta <= line_in;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end

   autobaud_detector u_autobaud (
      .sys_clk(sys_clk),
      .rst(rst),
      .line_level(line_sync),
      .locked(locked),
      .bit_clks(bit_clks)
   );

   assign half_clks = bit_clks >> 1;
   assign last_clk = bit_clks - 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // transmit fifo

   logic fifo_valid, fifo_ready;
   logic [7:0] fifo_data;

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(tx_valid),
      .in_data(tx_data),
      .in_ready(tx_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // receiver and command gating

   rx_state_e rx_state, next_rx_state;
   logic [BIT_W-1:0] rx_cnt, next_rx_cnt;
   logic [2:0] rx_idx, next_rx_idx;
   logic [7:0] rx_shift, next_rx_shift, next_rx_data, next_cmd_byte;
   logic next_rx_valid, next_cmd_valid, next_cmd_accept, next_cmd_refused;
   logic next_cmd_reserved, next_reg_access_ok;
   tx_state_e tx_state;

   always_comb begin
      next_rx_state = rx_state;
      next_rx_cnt = rx_cnt + 1'b1;
      next_rx_idx = rx_idx;
      next_rx_shift = rx_shift;
      next_rx_data = rx_data;
      next_rx_valid = 1'b0;
      next_cmd_valid = 1'b0;
      next_cmd_byte = cmd_byte;
      next_cmd_accept = 1'b0;
      next_cmd_refused = 1'b0;
      next_cmd_reserved = 1'b0;
      next_reg_access_ok = !(read_protect && reg_target_ram); // RL12
      case (rx_state)
         RX_IDLE: begin
            next_rx_cnt = '0;
            if (locked && tx_state == TX_IDLE && line_prev && !line_sync) begin
               next_rx_state = RX_START;
            end
         end
         RX_START: begin
            if (rx_cnt == half_clks) begin
               next_rx_cnt = '0;
               next_rx_idx = '0;
               next_rx_state = line_sync ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (rx_cnt == last_clk) begin
               next_rx_cnt = '0;
               next_rx_shift = {line_sync, rx_shift[7:1]};
               next_rx_idx = rx_idx + 1'b1;
               if (rx_idx == 3'h7) begin
                  next_rx_state = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rx_cnt == last_clk) begin
               next_rx_state = RX_IDLE;
               if (line_sync) begin
                  next_rx_valid = 1'b1;
                  next_rx_data = rx_shift;
                  if (cmd_expect) begin
                     next_cmd_valid = 1'b1;
                     next_cmd_byte = rx_shift;
                     if (!cmd_known(rx_shift)) begin
                        next_cmd_reserved = 1'b1; // RL11
                        next_cmd_refused = 1'b1;
                     end else if (!debug_mode && !cmd_free(rx_shift)) begin
                        next_cmd_refused = 1'b1; // RL10
                     end else if (read_protect && cmd_protected(rx_shift)) begin
                        next_cmd_refused = 1'b1; // RL10
                     end else begin
                        next_cmd_accept = 1'b1;
                     end
                  end
               end
            end
         end
         default: next_rx_state = RX_IDLE;
      endcase
      if (!locked) begin
         next_rx_state = RX_IDLE; // RL2
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_idx <= '0;
         rx_shift <= '0;
         rx_data <= '0;
         rx_valid <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_byte <= '0;
         cmd_accept <= 1'b0;
         cmd_refused <= 1'b0;
         cmd_reserved <= 1'b0;
         reg_access_ok <= 1'b1;
      end else begin
         rx_state <= next_rx_state;
         rx_cnt <= next_rx_cnt;
         rx_idx <= next_rx_idx;
         rx_shift <= next_rx_shift;
         rx_data <= next_rx_data;
         rx_valid <= next_rx_valid;
         cmd_valid <= next_cmd_valid;
         cmd_byte <= next_cmd_byte;
         cmd_accept <= next_cmd_accept;
         cmd_refused <= next_cmd_refused;
         cmd_reserved <= next_cmd_reserved;
         reg_access_ok <= next_reg_access_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter and line drive

   tx_state_e next_tx_state;
   logic [BIT_W-1:0] tx_cnt, next_tx_cnt;
   logic [2:0] tx_idx, next_tx_idx;
   logic [7:0] tx_shift, next_tx_shift;
   logic tx_bit, next_tx_bit, prev_bit, next_prev_bit;
   logic next_line_out, next_line_oe, next_baud_locked;
   logic [BIT_W-1:0] next_baud_bit_clks;
   logic first_clk, before_mid;

   assign fifo_ready = (tx_state == TX_IDLE) && locked && (rx_state == RX_IDLE);
   assign first_clk = (tx_cnt == '0);
   assign before_mid = (tx_cnt < half_clks);

   always_comb begin
      next_tx_state = tx_state;
      next_tx_cnt = tx_cnt + 1'b1;
      next_tx_idx = tx_idx;
      next_tx_shift = tx_shift;
      next_tx_bit = tx_bit;
      next_prev_bit = prev_bit;
      next_baud_locked = locked;
      next_baud_bit_clks = bit_clks; // RL6 RL1
      case (tx_state)
         TX_IDLE: begin
            next_tx_cnt = '0;
            next_tx_bit = 1'b1;
            next_prev_bit = 1'b1;
            if (fifo_valid && fifo_ready) begin
               next_tx_shift = fifo_data;
               next_tx_bit = 1'b0;
               next_tx_state = TX_START;
            end
         end
         TX_START, TX_DATA: begin
            if (tx_cnt == last_clk) begin
               next_tx_cnt = '0;
               next_prev_bit = tx_bit;
               next_tx_bit = tx_shift[0];
               next_tx_shift = {1'b1, tx_shift[7:1]};
               if (tx_state == TX_START) begin
                  next_tx_idx = '0;
                  next_tx_state = TX_DATA;
               end else begin
                  next_tx_idx = tx_idx + 1'b1;
                  if (tx_idx == 3'h7) begin
                     next_tx_bit = 1'b1;
                     next_tx_state = TX_STOP;
                  end
               end
            end
         end
         TX_STOP: begin
            if (tx_cnt == last_clk) begin
               next_tx_state = TX_IDLE;
            end
         end
         default: next_tx_state = TX_IDLE;
      endcase
      if (!locked) begin
         next_tx_state = TX_IDLE;
      end

      // default open drain: pull low or release
      next_line_out = 1'b0;
      next_line_oe = (tx_state != TX_IDLE) && !tx_bit; // RL13
      if (tx_state != TX_IDLE) begin
         if (full_drive && drive_high_assist_bit) begin
            if (tx_bit && !prev_bit && first_clk) begin
               next_line_out = 1'b1; // RL9
               next_line_oe = 1'b1;
            end
         end else if (full_drive) begin
            next_line_out = tx_bit; // RL7
            next_line_oe = (tx_state != TX_STOP) || before_mid;
         end else if (drive_high_assist_bit && tx_bit) begin
            next_line_out = 1'b1; // RL8
            next_line_oe = before_mid && (first_clk || !line_sync);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_cnt <= '0;
         tx_idx <= '0;
         tx_shift <= '0;
         tx_bit <= 1'b1;
         prev_bit <= 1'b1;
         line_out <= 1'b0;
         line_oe <= 1'b0;
         baud_locked <= 1'b0;
         baud_bit_clks <= BIT_W'(MAX_BIT_CLKS);
      end else begin
         tx_state <= next_tx_state;
         tx_cnt <= next_tx_cnt;
         tx_idx <= next_tx_idx;
         tx_shift <= next_tx_shift;
         tx_bit <= next_tx_bit;
         prev_bit <= next_prev_bit;
         line_out <= next_line_out;
         line_oe <= next_line_oe;
         baud_locked <= next_baud_locked;
         baud_bit_clks <= next_baud_bit_clks;
      end
   end
endmodule // serial_debug_unit

/* File: tb/serial_debug_unit_sva.sv */
/*
 serial_debug_unit_sva: port-level checks of the serial debug unit.
 assumes: bound to serial_debug_unit; one clock, async active-high reset.
*/
`timescale 1ns/10ps
module serial_debug_unit_sva
   import serial_debug_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic full_drive,
   input wire logic drive_high_assist_bit,
   input wire logic debug_mode,
   input wire logic read_protect,
   input wire logic rx_valid,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_accept,
   input wire logic cmd_refused,
   input wire logic cmd_reserved,
   input wire logic reg_target_ram,
   input wire logic reg_access_ok,
   input wire logic baud_locked,
   input wire logic [BIT_W-1:0] baud_bit_clks
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [12:0] low_cnt;
   logic [12:0] next_low_cnt;
   always_comb next_low_cnt = line_in ? 13'h0000 : low_cnt + 13'h0001;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) low_cnt <= 13'h0000;
      else low_cnt <= next_low_cnt;
   end
   ////////////////////////////////////////////////////////////////////////////
   AST_BREAK_UNLOCK: assert property (int'(low_cnt) == 10 * int'(baud_bit_clks) + 8
      |-> !baud_locked) else $error("lock kept through a break");
   AST_RATE_RANGE: assert property (baud_locked |-> baud_bit_clks >= 10'h008
      && baud_bit_clks <= 10'h200) else $error("bit period outside limits");
   AST_CMD_SHAPE: assert property (cmd_valid |-> rx_valid && (cmd_accept ^ cmd_refused)
      && (!cmd_reserved || cmd_refused)) else $error("command pulse set malformed");
   AST_RESERVED: assert property (cmd_valid |-> cmd_reserved == (cmd_byte == 8'h0f
      || (cmd_byte > 8'h12 && !(cmd_byte inside {8'h18, 8'h19, 8'h1b}))))
      else $error("reserved flag wrong");
   AST_FREE_SET: assert property (cmd_valid && !$past(debug_mode) && cmd_accept
      |-> cmd_byte inside {8'h00, 8'h02, 8'h04, 8'h05}) else $error("command run outside debug");
   AST_PROTECT: assert property (cmd_valid && $past(read_protect)
      && cmd_byte inside {[8'h06:8'h07], [8'h0a:8'h0d], [8'h10:8'h12]} |-> cmd_refused)
      else $error("protected command accepted");
   AST_RAM_GATE: assert property (reg_access_ok == !($past(read_protect)
      && $past(reg_target_ram))) else $error("register access gate wrong");
   AST_OPEN_DRAIN: assert property (!full_drive && !drive_high_assist_bit && line_oe
      |-> !line_out) else $error("line driven high without drive option");
   AST_KICK_ONE: assert property (full_drive && drive_high_assist_bit && line_oe
      && line_out |=> !(line_oe && line_out)) else $error("high kick longer than a clock");
   AST_FULL_START: assert property (full_drive && !drive_high_assist_bit && $rose(line_oe)
      |-> !line_out) else $error("full drive not opened by start bit");
endmodule // serial_debug_unit_sva

/* File: tb/debug_host_model.sv */
/*
 debug_host_model: debug host on the open-drain line, sends and receives frames.
 assumes: line is the wired level; bit_p is set by the bench before a frame.
*/
`timescale 1ns/10ps
module debug_host_model (
   input wire logic sys_clk,
   input wire logic line,
   input wire logic [9:0] bit_p,
   output logic host_low,
   output logic host_rx_valid,
   output logic [7:0] host_rx_data
);
   // host only pulls low, paced by the same clock as the device
   initial {host_low, host_rx_valid, host_rx_data} = 10'h000;
   task automatic hold_low(input int n);
      host_low = 1'b1;
      repeat (n) @(negedge sys_clk);
      host_low = 1'b0;
   endtask
   // bench keeps bit_p within 8..512 clocks
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_low = !f[i];
         repeat (bit_p) @(negedge sys_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // receiver: start seen only when the device pulls the line
   always begin
      logic [7:0] d;
      @(posedge sys_clk);
      if (!line && !host_low) begin
         repeat (bit_p / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_p) @(posedge sys_clk);
            d[i] = line;
         end
         repeat (bit_p) @(posedge sys_clk);
         if (line) begin
            host_rx_data = d;
            host_rx_valid = 1'b1;
            @(posedge sys_clk);
            host_rx_valid = 1'b0;
         end
      end
   end
endmodule // debug_host_model

/* File: tb/serial_debug_unit_tb.sv */
/*
 serial_debug_unit_tb: autobaud, break, drive modes, fifo and command gating.
 assumes: host model on the line with an ideal pull-up; 40 MHz clock.
*/
`timescale 1ns/10ps
module serial_debug_unit_tb;
   import serial_debug_pkg::*;
   logic sys_clk, rst, line, host_low, line_out, line_oe, full_drive, drive_high_assist_bit;
   logic debug_mode, read_protect, tx_valid, tx_ready, rx_valid, cmd_expect, cmd_valid;
   logic cmd_accept, cmd_refused, cmd_reserved, reg_target_ram, reg_access_ok, baud_locked;
   logic host_rx_valid, counting;
   logic [7:0] tx_data, rx_data, cmd_byte, host_rx_data, b;
   logic [9:0] bit_p, baud_bit_clks;
   logic [31:0] seed = 32'hdc87;
   logic [7:0] exp_rx[$];
   logic [10:0] exp_cmd[$];
   logic [7:0] exp_tx[$];
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int hi, lo;
   assign line = !host_low && (line_oe ? line_out : 1'b1);
   serial_debug_unit u_dut (.sys_clk(sys_clk), .rst(rst), .line_in(line), .line_out(line_out),
      .line_oe(line_oe), .full_drive(full_drive), .drive_high_assist_bit(drive_high_assist_bit),
      .debug_mode(debug_mode), .read_protect(read_protect), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .cmd_expect(cmd_expect), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .cmd_accept(cmd_accept), .cmd_refused(cmd_refused), .cmd_reserved(cmd_reserved),
      .reg_target_ram(reg_target_ram), .reg_access_ok(reg_access_ok),
      .baud_locked(baud_locked), .baud_bit_clks(baud_bit_clks));
   debug_host_model u_host (.sys_clk(sys_clk), .line(line), .bit_p(bit_p), .host_low(host_low),
      .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = !sys_clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // {accept, refused, reserved} for a command byte
   function automatic logic [2:0] cls(input logic [7:0] c, input logic dm, input logic rp);
      logic res, rf;
      res = (c == 8'h0f) || (c > 8'h12 && c != 8'h18 && c != 8'h19 && c != 8'h1b);
      rf = res || (!dm && !(c inside {8'h00, 8'h02, 8'h04, 8'h05}))
         || (rp && (c inside {[8'h06:8'h07], [8'h0a:8'h0d], [8'h10:8'h12]}));
      return {!rf, rf, res};
   endfunction
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic put_tx(input logic [7:0] d);
      @(negedge sys_clk);
      tx_valid = 1'b1;
      tx_data = d;
      do @(posedge sys_clk); while (tx_ready !== 1'b1);
      @(negedge sys_clk);
      tx_valid = 1'b0;
   endtask
   task automatic wait_tx();
      for (int k = 0; k < 3000 && exp_tx.size() > 0; k++) @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      chk("tx drained", 0, exp_tx.size());
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // result watcher
   always @(negedge sys_clk) begin
      cycles++;
      reg_target_ram = cycles[2] ^ cycles[5];
      if (counting) begin
         hi += int'(line_oe && line_out);
         lo += int'(line_oe && !line_out);
      end
      if (rx_valid === 1'b1)
         chk("rx_data", exp_rx.size() ? exp_rx.pop_front() : 8'hxx, rx_data);
      if (cmd_valid === 1'b1)
         chk("cmd", exp_cmd.size() ? exp_cmd.pop_front() : 11'hxxx,
            {cmd_byte, cmd_accept, cmd_refused, cmd_reserved});
      if (host_rx_valid === 1'b1)
         chk("tx byte", exp_tx.size() ? exp_tx.pop_front() : 8'hxx, host_rx_data);
      if (cycles > 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, full_drive, drive_high_assist_bit, debug_mode, read_protect} = 5'h10;
      {tx_valid, cmd_expect, counting} = 3'h0;
      tx_data = 8'h00;
      bit_p = 10'h010;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      chk("reset rate", 16'h0200, baud_bit_clks);
      chk("reset gate", 1, reg_access_ok);
      u_host.hold_low(4200);
      repeat (20) @(negedge sys_clk);
      chk("overflow lock", 0, baud_locked);
      $display("test overflow done");
      u_host.send_byte(8'h80);
      repeat (8) @(negedge sys_clk);
      chk("rate 16", 16'h0410, {baud_locked, baud_bit_clks});
      for (int m = 0; m < 4; m++) begin
         {drive_high_assist_bit, full_drive} = m[1:0];
         {hi, lo} = 0;
         counting = 1'b1;
         exp_tx.push_back(8'h55);
         put_tx(8'h55);
         wait_tx();
         counting = 1'b0;
         chk("low drive", 80, lo);
         if (m == 0) chk("no high", 0, hi);
         if (m == 1) chk("full high", 72, hi);
         if (m == 2) chk("assist high", 1, hi >= 4 && hi <= 40);
         if (m == 3) chk("kick high", 5, hi);
      end
      $display("test drive modes done");
      u_host.hold_low(180);
      repeat (10) @(negedge sys_clk);
      chk("break lock", 0, baud_locked);
      for (int i = 0; i < 16; i++) begin
         b = 8'(xs());
         exp_tx.push_back(b);
         put_tx(b);
      end
      chk("fifo full", 0, tx_ready);
      @(negedge sys_clk);
      tx_valid = 1'b1;
      tx_data = 8'hee;
      repeat (3) @(negedge sys_clk);
      tx_valid = 1'b0;
      bit_p = 10'h008;
      u_host.send_byte(8'h80);
      chk("rate 8", 16'h0408, {baud_locked, baud_bit_clks});
      wait_tx();
      $display("test fifo and high rate done");
      for (int i = 0; i < 32; i++) begin
         b = (i < 28) ? 8'(i) : 8'(xs());
         {debug_mode, read_protect} = 2'(xs());
         cmd_expect = (i % 9 != 5);
         exp_rx.push_back(b);
         if (cmd_expect) exp_cmd.push_back({b, cls(b, debug_mode, read_protect)});
         u_host.send_byte(b);
      end
      repeat (40) @(negedge sys_clk);
      chk("commands left", 0, exp_rx.size() + exp_cmd.size());
      $display("test commands done");
      give_verdict();
   end
endmodule // serial_debug_unit_tb
bind serial_debug_unit serial_debug_unit_sva u_sva (.sys_clk(sys_clk), .rst(rst),
   .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .full_drive(full_drive),
   .drive_high_assist_bit(drive_high_assist_bit), .debug_mode(debug_mode),
   .read_protect(read_protect), .rx_valid(rx_valid), .cmd_valid(cmd_valid),
   .cmd_byte(cmd_byte), .cmd_accept(cmd_accept), .cmd_refused(cmd_refused),
   .cmd_reserved(cmd_reserved), .reg_target_ram(reg_target_ram),
   .reg_access_ok(reg_access_ok), .baud_locked(baud_locked), .baud_bit_clks(baud_bit_clks));
